//--- dv/cbsc_txn_src.sv
// Purpose: upstream master model presenting one transaction's attributes
// Assumes: send is called right after a rising edge, at most once a cycle
// Notes: idle attributes invert, so a stale value never passes for a live one
`timescale 1ns/100ps
module cbsc_txn_src (
	input  wire logic        clk_sys,
	output logic             txn_valid,
	output logic      [10:0] txn_attr
);
	initial begin
		txn_valid = 1'b0;
		txn_attr  = 11'h000;
	end
	task automatic send(input logic [10:0] a);
		txn_valid <= 1'b1;
		txn_attr  <= a;
		@(posedge clk_sys);
		txn_valid <= 1'b0;
		txn_attr  <= ~a;
	endtask : send
endmodule : cbsc_txn_src

//--- dv/tb_top.sv
// Purpose: self-checking bench for the context bank control block
// Assumes: apb slave answers by itself, attribute path registered once
// Notes: reset held 10 cycles; a watchdog cuts a hang short
`timescale 1ns/100ps
module tb_top;
	import cbsc_pkg::*;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, rd;
	logic [2:0]  st = 3'h5;
	logic [6:0]  fl = 7'h00;
	wire  [31:0] prdata;
	wire         pready, pslverr, out_valid, txn_valid, perm, acc, rsv;
	wire  [10:0] oa, ta;
	wire  [3:0]  of, oc;
	int          err_count = 0, checks_done = 0;
	always #25 clk_sys = ~clk_sys;
	cbsc_txn_src i_src (.clk_sys(clk_sys), .txn_valid(txn_valid), .txn_attr(ta));
	cbsc_top i_dut (
		.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.bank_secure(st[2]), .long_descriptor_enable(st[1]), .transient_present(st[0]),
		.txn_valid(txn_valid), .txn_nonsecure(ta[10]), .txn_write_alloc(ta[9]),
		.txn_read_alloc(ta[8]), .txn_share(ta[7:6]), .txn_bypass_memory_attributes(ta[5:2]),
		.txn_transient(ta[1:0]), .txn_fetch(fl[6]), .txn_unpriv_writable(fl[5]),
		.txn_writable(fl[4]), .txn_access_bit(fl[3]), .context_fault(fl[2]),
		.fault_outstanding(fl[1]), .txn_exclusive(fl[0]), .out_valid(out_valid),
		.out_nonsecure(oa[10]), .out_write_alloc(oa[9]), .out_read_alloc(oa[8]),
		.out_share(oa[7:6]), .out_bypass_memory_attributes(oa[5:2]), .out_transient(oa[1:0]),
		.out_perm_fault(perm), .out_access_fault(acc), .out_hold(of[0]),
		.fault_stall(of[3]), .fault_abort(of[2]), .fault_irq(of[1]),
		.ctl_big_endian(oc[3]), .ctl_private_namespace(oc[2]), .ctl_afe_eff(oc[1]),
		.ctl_tre_eff(oc[0]), .attr_reserved(rsv)
	);
	task automatic summarize();
		if (err_count == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : summarize
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// request held until pready is seen at an edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1) @(posedge clk_sys);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask : apb
	// outputs registered at the edge that took the transaction
	task automatic xfer(input logic [10:0] a, output logic [13:0] o, output logic [3:0] f);
		i_src.send(a);
		fl[2] <= 1'b0;
		@(negedge clk_sys);
		o = {out_valid, oa, perm, acc};
		f = of;
		@(posedge clk_sys);
	endtask : xfer
	task automatic t_reset();
		apb(1'b0, CBSC_ADDR_CTRL, 32'h0, rd, er);
		chk(32'(rd[6:5]), 32'h0);
		apb(1'b0, 12'h008, 32'h0, rd, er);
		chk({31'h0, er}, 32'h1);
	endtask : t_reset
	task automatic t_rw();
		st <= 3'h0;
		apb(1'b1, CBSC_ADDR_CTRL, 32'hffff_ffff, rd, er);
		apb(1'b0, CBSC_ADDR_CTRL, 32'h0, rd, er);
		chk(rd, 32'h0fdf_17ff);
		st <= 3'h5;
		apb(1'b1, CBSC_ADDR_CTRL, 32'hffff_ffff, rd, er);
		apb(1'b0, CBSC_ADDR_CTRL, 32'h0, rd, er);
		chk(rd, 32'h3fdf_d7ff);
	endtask : t_rw
	task automatic t_bypass();
		logic [1:0]  c;
		logic [10:0] a, e;
		logic [13:0] o;
		logic [3:0]  f;
		for (int i = 0; i < 8; i++) begin
			c = i[2:1];
			a = i[0] ? 11'h4b5 : 11'h34a;
			apb(1'b1, CBSC_ADDR_CTRL, {2'h0, c, c, c, c, 1'b0, c != 2'h0, 4'h9, c, 14'h0}, rd, er);
			e[10]   = c[1] ? c[0] : a[10];
			e[9]    = c[1] ? ~c[0] : a[9];
			e[8]    = c[1] ? ~c[0] : a[8];
			e[7:6]  = (c != 2'h0) ? c : a[7:6];
			e[5:2]  = (c != 2'h0) ? 4'h9 : a[5:2];
			e[1:0]  = c[1] ? c : a[1:0];
			xfer(a, o, f);
			chk(32'(o[13:2]), {20'h0, 1'b1, e});
		end
	endtask : t_bypass
	// reserved attribute codes: flag output and status bit 5
	task automatic t_attr();
		logic [3:0] mc [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'hf};
		logic       mb [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
		for (int k = 0; k < 6; k++) begin
			apb(1'b1, CBSC_ADDR_CTRL, {11'h0, 1'b1, mc[k], 16'h0}, rd, er);
			@(negedge clk_sys);
			chk({31'h0, rsv}, {31'h0, mb[k]});
			@(posedge clk_sys);
			apb(1'b0, CBSC_ADDR_STATUS, 32'h0, rd, er);
			chk(rd, {26'h0, mb[k], 5'h06});
		end
	endtask : t_attr
	task automatic t_trans();
		logic [31:0] tw [6] = '{32'h3fd0_0201, 32'h3fd0_0401, 32'h3fd0_0001,
			32'h3fd0_0005, 32'h3fd0_000d, 32'h0000_0200};
		logic [6:0]  tf [6] = '{7'h58, 7'h68, 7'h78, 7'h00, 7'h00, 7'h58};
		logic [1:0]  te [6] = '{2'h2, 2'h2, 2'h0, 2'h1, 2'h0, 2'h0};
		logic [13:0] o;
		logic [3:0]  f;
		for (int k = 0; k < 6; k++) begin
			apb(1'b1, CBSC_ADDR_CTRL, tw[k], rd, er);
			fl <= tf[k];
			xfer(11'h4b5, o, f);
			chk(32'(o[1:0]), 32'(te[k]));
			if (k < 5) chk(32'(o[12:2]), 32'h4b5);
		end
		fl <= 7'h00;
	endtask : t_trans
	task automatic t_fault();
		logic [31:0] tw [3] = '{32'h0000_00e0, 32'h0000_0100, 32'h0};
		logic [6:0]  tf [3] = '{7'h07, 7'h07, 7'h06};
		logic [3:0]  te [3] = '{4'hf, 4'h4, 4'h1};
		logic [13:0] o;
		logic [3:0]  f;
		for (int k = 0; k < 3; k++) begin
			apb(1'b1, CBSC_ADDR_CTRL, tw[k], rd, er);
			fl <= tf[k];
			xfer(11'h0, o, f);
			chk(32'(f), 32'(te[k]));
		end
		fl <= 7'h00;
	endtask : t_fault
	task automatic t_ctl();
		apb(1'b1, CBSC_ADDR_CTRL, 32'h0000_1010, rd, er);
		repeat (2) @(posedge clk_sys);
		chk(32'(oc), 32'hc);
		st <= 3'h7;
		repeat (3) @(posedge clk_sys);
		chk(32'(oc), 32'hf);
		st <= 3'h5;
		apb(1'b1, CBSC_ADDR_CTRL, 32'h0000_0002, rd, er);
		repeat (2) @(posedge clk_sys);
		chk(32'(oc), 32'h1);
	endtask : t_ctl
	initial begin
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		t_reset();
		t_rw();
		t_bypass();
		t_attr();
		t_trans();
		t_fault();
		t_ctl();
		summarize();
	end
	// whole run needs under two hundred cycles
	initial begin
		repeat (3000) @(posedge clk_sys);
		err_count++;
		summarize();
	end
endmodule : tb_top

//--- pkg/cbsc_pkg.sv
// Purpose: constants for the context bank system control block
// Assumes: one 32-bit control word reached over apb, 20 mhz clk_sys
// Notes: field positions and encodings of the control word
package cbsc_pkg;
	localparam logic [11:0] CBSC_ADDR_CTRL    = 12'h000;
	localparam logic [11:0] CBSC_ADDR_STATUS  = 12'h004;
	localparam logic [31:0] CBSC_CTRL_RESET   = 32'h0000_0000;
	localparam logic [31:0] CBSC_WRITE_MASK   = 32'h3fdf_d7ff;
	localparam int          CBSC_NSB_LO       = 28;
	localparam int          CBSC_WAB_LO       = 26;
	localparam int          CBSC_RAB_LO       = 24;
	localparam int          CBSC_SHB_LO       = 22;
	localparam int          CBSC_MTS_BIT      = 20;
	localparam int          CBSC_BYPASS_MEMORY_ATTRIBUTES_LO   = 16;
	localparam int          CBSC_TRB_LO       = 14;
	localparam int          CBSC_PNE_BIT      = 12;
	localparam int          CBSC_UNPRIV_WRITE_EXEC_NEVER_BIT     = 10;
	localparam int          CBSC_WXN_BIT      = 9;
	localparam int          CBSC_HUF_BIT      = 8;
	localparam int          CBSC_STALL_BIT    = 7;
	localparam int          CBSC_FIE_BIT      = 6;
	localparam int          CBSC_FRE_BIT      = 5;
	localparam int          CBSC_END_BIT      = 4;
	localparam int          CBSC_ACCESS_FLAG_FAULT_DISABLE_BIT     = 3;
	localparam int          CBSC_AFE_BIT      = 2;
	localparam int          CBSC_TRE_BIT      = 1;
	localparam int          CBSC_EN_BIT       = 0;
	localparam logic [1:0]  CBSC_FORCE_ON     = 2'h2;
	localparam logic [1:0]  CBSC_FORCE_OFF    = 2'h3;
	localparam logic [1:0]  CBSC_SH_OUTER     = 2'h1;
	localparam logic [1:0]  CBSC_SH_INNER     = 2'h2;
	localparam logic [1:0]  CBSC_SH_NONE      = 2'h3;
	localparam logic [1:0]  CBSC_OUTER_DEV    = 2'h0;
	localparam logic [1:0]  CBSC_SO_CODE      = 2'h0;
	localparam logic [1:0]  CBSC_DEV_CODE     = 2'h1;
endpackage : cbsc_pkg

//--- src/cbsc_top.sv
// Purpose: control word of one context bank plus the bypass attribute path
// Assumes: attributes of a passing transaction arrive as plain inputs, same clock
// Notes: apb slave answers with zero wait states; outputs are registered
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
module cbsc_top (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        bank_secure,
	input  wire logic        long_descriptor_enable,
	input  wire logic        transient_present,
	input  wire logic        txn_valid,
	input  wire logic        txn_nonsecure,
	input  wire logic        txn_write_alloc,
	input  wire logic        txn_read_alloc,
	input  wire logic [1:0]  txn_share,
	input  wire logic [3:0]  txn_bypass_memory_attributes,
	input  wire logic [1:0]  txn_transient,
	input  wire logic        txn_fetch,
	input  wire logic        txn_unpriv_writable,
	input  wire logic        txn_writable,
	input  wire logic        txn_access_bit,
	input  wire logic        context_fault,
	input  wire logic        fault_outstanding,
	input  wire logic        txn_exclusive,
	output logic             out_valid,
	output logic             out_nonsecure,
	output logic             out_write_alloc,
	output logic             out_read_alloc,
	output logic      [1:0]  out_share,
	output logic      [3:0]  out_bypass_memory_attributes,
	output logic      [1:0]  out_transient,
	output logic             out_perm_fault,
	output logic             out_access_fault,
	output logic             out_hold,
	output logic             fault_stall,
	output logic             fault_abort,
	output logic             fault_irq,
	output logic             ctl_big_endian,
	output logic             ctl_private_namespace,
	output logic             ctl_afe_eff,
	output logic             ctl_tre_eff,
	output logic             attr_reserved
);
	import cbsc_pkg::*;

	logic [31:0] ctrl_reg;
	logic [31:0] wmask;
	logic        wr_en;
	logic        rd_en;
	logic        hit_ctrl;
	logic        hit_stat;
	logic [31:0] stat_word;
	logic        xlate_on;
	logic        afe_eff;
	logic [1:0]  nsb;
	logic [1:0]  wab;
	logic [1:0]  rab;
	logic [1:0]  shb;
	logic [3:0]  mattr;
	logic [1:0]  trb;
	logic        mattr_bad;

	assign hit_ctrl = (paddr == CBSC_ADDR_CTRL);
	assign hit_stat = (paddr == CBSC_ADDR_STATUS);
	assign wr_en    = psel & penable & pwrite & pready;
	assign rd_en    = psel & ~penable & ~pwrite;
	assign xlate_on = ctrl_reg[CBSC_EN_BIT];
	assign nsb      = ctrl_reg[CBSC_NSB_LO+:2];
	assign wab      = ctrl_reg[CBSC_WAB_LO+:2];
	assign rab      = ctrl_reg[CBSC_RAB_LO+:2];
	assign shb      = ctrl_reg[CBSC_SHB_LO+:2];
	assign mattr    = ctrl_reg[CBSC_BYPASS_MEMORY_ATTRIBUTES_LO+:4];
	assign trb      = ctrl_reg[CBSC_TRB_LO+:2];
	assign afe_eff  = ctrl_reg[CBSC_AFE_BIT] | long_descriptor_enable;

	always_comb begin
		wmask = CBSC_WRITE_MASK;
		if (!bank_secure) begin
			wmask[CBSC_NSB_LO+:2] = 2'h0;
		end
		if (!transient_present) begin
			wmask[CBSC_TRB_LO+:2] = 2'h0;
		end
	end

	always_comb begin
		if (mattr[3:2] == CBSC_OUTER_DEV) begin
			mattr_bad = (mattr[1:0] != CBSC_SO_CODE) && (mattr[1:0] != CBSC_DEV_CODE);
		end else begin
			mattr_bad = (mattr[1:0] == 2'h0);
		end
	end

	assign stat_word = {26'h0, mattr_bad, fault_outstanding, long_descriptor_enable,
		transient_present, bank_secure, xlate_on};

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ctrl_reg <= CBSC_CTRL_RESET;
		end else if (wr_en && hit_ctrl) begin
			ctrl_reg <= pwdata & wmask;
		end else begin
			ctrl_reg <= ctrl_reg & wmask;
		end
	end

	// zero wait: ready registered at the edge ending the setup cycle so the access ends at once
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~(hit_ctrl | hit_stat);
			if (rd_en) begin
				prdata <= hit_ctrl ? ctrl_reg : (hit_stat ? stat_word : 32'h0);
			end
		end
	end

	// attribute path, one stage
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			out_valid        <= 1'b0;
			out_nonsecure    <= 1'b0;
			out_write_alloc  <= 1'b0;
			out_read_alloc   <= 1'b0;
			out_share        <= 2'h0;
			out_bypass_memory_attributes      <= 4'h0;
			out_transient    <= 2'h0;
			out_perm_fault   <= 1'b0;
			out_access_fault <= 1'b0;
			out_hold         <= 1'b0;
		end else begin
			out_valid <= txn_valid;
			out_nonsecure   <= txn_nonsecure;
			out_write_alloc <= txn_write_alloc;
			out_read_alloc  <= txn_read_alloc;
			out_share       <= txn_share;
			out_bypass_memory_attributes     <= txn_bypass_memory_attributes;
			out_transient   <= txn_transient;
			if (!xlate_on) begin
				if (nsb == CBSC_FORCE_ON) out_nonsecure <= 1'b0;
				if (nsb == CBSC_FORCE_OFF) out_nonsecure <= 1'b1;
				if (wab == CBSC_FORCE_ON) out_write_alloc <= 1'b1;
				if (wab == CBSC_FORCE_OFF) out_write_alloc <= 1'b0;
				if (rab == CBSC_FORCE_ON) out_read_alloc <= 1'b1;
				if (rab == CBSC_FORCE_OFF) out_read_alloc <= 1'b0;
				if (shb != 2'h0) out_share <= shb;
				if (ctrl_reg[CBSC_MTS_BIT]) out_bypass_memory_attributes <= mattr;
				if (trb == CBSC_FORCE_ON || trb == CBSC_FORCE_OFF) out_transient <= trb;
			end
			out_perm_fault <= txn_valid & xlate_on & txn_fetch &
				((ctrl_reg[CBSC_UNPRIV_WRITE_EXEC_NEVER_BIT] & txn_unpriv_writable) |
				 (ctrl_reg[CBSC_WXN_BIT] & txn_writable));
			out_access_fault <= txn_valid & xlate_on & afe_eff &
				~ctrl_reg[CBSC_ACCESS_FLAG_FAULT_DISABLE_BIT] & ~txn_access_bit;
			out_hold <= fault_outstanding & ~ctrl_reg[CBSC_HUF_BIT];
		end
	end

	// fault response and static controls
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			fault_stall           <= 1'b0;
			fault_abort           <= 1'b0;
			fault_irq             <= 1'b0;
			ctl_big_endian        <= 1'b0;
			ctl_private_namespace <= 1'b0;
			ctl_afe_eff           <= 1'b0;
			ctl_tre_eff           <= 1'b0;
			attr_reserved         <= 1'b0;
		end else begin
			fault_stall <= context_fault & ctrl_reg[CBSC_STALL_BIT];
			fault_abort <= context_fault & (ctrl_reg[CBSC_FRE_BIT] | txn_exclusive);
			fault_irq <= context_fault & ctrl_reg[CBSC_FIE_BIT];
			ctl_big_endian <= ctrl_reg[CBSC_END_BIT];
			ctl_private_namespace <= ctrl_reg[CBSC_PNE_BIT];
			ctl_afe_eff <= afe_eff;
			ctl_tre_eff <= ctrl_reg[CBSC_TRE_BIT] | long_descriptor_enable;
			attr_reserved <= mattr_bad & ctrl_reg[CBSC_MTS_BIT] & ~xlate_on;
		end
	end

	chk_reserved_zero: assert property (@(posedge clk_sys) disable iff (rst)
		(ctrl_reg & ~CBSC_WRITE_MASK) == 32'h0)
		else $error("reserved control bits set");
	chk_reset_bits: assert property (@(posedge clk_sys) disable iff (rst)
		$fell(rst) |-> ctrl_reg[CBSC_FRE_BIT+:2] == 2'h0)
		else $error("fault enables not clear after reset");
	chk_write_lands: assert property (@(posedge clk_sys) disable iff (rst)
		wr_en && hit_ctrl && bank_secure && transient_present |=>
		ctrl_reg == ($past(pwdata) & CBSC_WRITE_MASK))
		else $error("control write lost");
	chk_apb_ready: assert property (@(posedge clk_sys) disable iff (rst)
		psel && !penable |=> pready ##1 !pready)
		else $error("apb answer timing");
	chk_secure_gate: assert property (@(posedge clk_sys) disable iff (rst)
		!bank_secure |=> ctrl_reg[CBSC_NSB_LO+:2] == 2'h0)
		else $error("security field kept in non-secure bank");

	chk_force_secure: assert property (@(posedge clk_sys) disable iff (rst)
		!xlate_on && nsb == CBSC_FORCE_ON |=> !out_nonsecure)
		else $error("secure override missed");
	chk_force_nonsec: assert property (@(posedge clk_sys) disable iff (rst)
		!xlate_on && nsb == CBSC_FORCE_OFF |=> out_nonsecure)
		else $error("non-secure override missed");
	chk_wa_force: assert property (@(posedge clk_sys) disable iff (rst)
		!xlate_on && wab == CBSC_FORCE_OFF |=> !out_write_alloc)
		else $error("write allocate override missed");
	chk_wa_on: assert property (@(posedge clk_sys) disable iff (rst)
		!xlate_on && wab == CBSC_FORCE_ON |=> out_write_alloc)
		else $error("write allocate force missed");
	chk_ra_force: assert property (@(posedge clk_sys) disable iff (rst)
		!xlate_on && rab == CBSC_FORCE_ON |=> out_read_alloc)
		else $error("read allocate override missed");
	chk_ra_off: assert property (@(posedge clk_sys) disable iff (rst)
		!xlate_on && rab == CBSC_FORCE_OFF |=> !out_read_alloc)
		else $error("read allocate removal missed");
	chk_share_force: assert property (@(posedge clk_sys) disable iff (rst)
		!xlate_on && shb != 2'h0 |=> out_share == $past(shb))
		else $error("shareability override missed");
	chk_memtype_ovl: assert property (@(posedge clk_sys) disable iff (rst)
		!xlate_on && ctrl_reg[CBSC_MTS_BIT] |=> out_bypass_memory_attributes == $past(mattr))
		else $error("memory attribute overlay missed");
	chk_memtype_keep: assert property (@(posedge clk_sys) disable iff (rst)
		!ctrl_reg[CBSC_MTS_BIT] |=> out_bypass_memory_attributes == $past(txn_bypass_memory_attributes))
		else $error("memory attribute changed without select");
	chk_attr_rsvd: assert property (@(posedge clk_sys) disable iff (rst)
		!xlate_on && ctrl_reg[CBSC_MTS_BIT] && mattr_bad |=> attr_reserved)
		else $error("reserved attribute code not flagged");
	chk_trans_ovr: assert property (@(posedge clk_sys) disable iff (rst)
		!xlate_on && trb[1] |=> out_transient == $past(trb))
		else $error("transient override missed");
	chk_trans_absent: assert property (@(posedge clk_sys) disable iff (rst)
		!transient_present |=> trb == 2'h0)
		else $error("absent transient field kept");

	chk_pne_follow: assert property (@(posedge clk_sys) disable iff (rst)
		1'b1 |=> ctl_private_namespace == $past(ctrl_reg[CBSC_PNE_BIT]))
		else $error("namespace hint stale");
	chk_unpriv_write_exec_never_fault: assert property (@(posedge clk_sys) disable iff (rst)
		txn_valid && xlate_on && txn_fetch && txn_unpriv_writable &&
		ctrl_reg[CBSC_UNPRIV_WRITE_EXEC_NEVER_BIT] |=> out_perm_fault)
		else $error("unprivileged write-exec-never fault missed");
	chk_wxn_fault: assert property (@(posedge clk_sys) disable iff (rst)
		txn_valid && xlate_on && txn_fetch && txn_writable && ctrl_reg[CBSC_WXN_BIT]
		|=> out_perm_fault)
		else $error("write-exec-never fault missed");
	chk_xn_off: assert property (@(posedge clk_sys) disable iff (rst)
		!xlate_on |=> !out_perm_fault)
		else $error("permission fault while bypassing");
	chk_hold_gate: assert property (@(posedge clk_sys) disable iff (rst)
		fault_outstanding && !ctrl_reg[CBSC_HUF_BIT] |=> out_hold)
		else $error("hold behind fault missed");
	chk_hold_free: assert property (@(posedge clk_sys) disable iff (rst)
		ctrl_reg[CBSC_HUF_BIT] |=> !out_hold)
		else $error("hold raised with hit under fault");
	chk_stall_sel: assert property (@(posedge clk_sys) disable iff (rst)
		context_fault |=> fault_stall == $past(ctrl_reg[CBSC_STALL_BIT]))
		else $error("fault model not followed");
	chk_irq_gate: assert property (@(posedge clk_sys) disable iff (rst)
		fault_irq |-> $past(context_fault) && $past(ctrl_reg[CBSC_FIE_BIT]))
		else $error("interrupt without enabled fault");
	chk_irq_raise: assert property (@(posedge clk_sys) disable iff (rst)
		context_fault && ctrl_reg[CBSC_FIE_BIT] |=> fault_irq)
		else $error("fault interrupt missed");
	chk_abort_report: assert property (@(posedge clk_sys) disable iff (rst)
		context_fault && ctrl_reg[CBSC_FRE_BIT] |=> fault_abort)
		else $error("fault abort missed");
	chk_abort_excl: assert property (@(posedge clk_sys) disable iff (rst)
		context_fault && txn_exclusive |=> fault_abort)
		else $error("exclusive fault not reported");

	chk_endian_follow: assert property (@(posedge clk_sys) disable iff (rst)
		1'b1 |=> ctl_big_endian == $past(ctrl_reg[CBSC_END_BIT]))
		else $error("table endianness stale");
	chk_af_fault: assert property (@(posedge clk_sys) disable iff (rst)
		txn_valid && xlate_on && afe_eff && !ctrl_reg[CBSC_ACCESS_FLAG_FAULT_DISABLE_BIT] &&
		!txn_access_bit |=> out_access_fault)
		else $error("access flag fault missed");
	chk_af_disable: assert property (@(posedge clk_sys) disable iff (rst)
		ctrl_reg[CBSC_ACCESS_FLAG_FAULT_DISABLE_BIT] |=> !out_access_fault)
		else $error("access fault while disabled");
	chk_afe_forced: assert property (@(posedge clk_sys) disable iff (rst)
		long_descriptor_enable |=> ctl_afe_eff)
		else $error("access flag not forced by long tables");
	chk_tre_forced: assert property (@(posedge clk_sys) disable iff (rst)
		long_descriptor_enable |=> ctl_tre_eff)
		else $error("remap not forced by long tables");
	chk_xlate_pass: assert property (@(posedge clk_sys) disable iff (rst)
		xlate_on |=> out_nonsecure == $past(txn_nonsecure) &&
		out_bypass_memory_attributes == $past(txn_bypass_memory_attributes))
		else $error("override applied while translating");
	chk_share_pass: assert property (@(posedge clk_sys) disable iff (rst)
		xlate_on |=> out_share == $past(txn_share))
		else $error("attribute altered while translating");
	chk_default_pass: assert property (@(posedge clk_sys) disable iff (rst)
		!xlate_on && !nsb[1] |=> out_nonsecure == $past(txn_nonsecure))
		else $error("default security code altered attribute");
	chk_valid_follow: assert property (@(posedge clk_sys) disable iff (rst)
		1'b1 |=> out_valid == $past(txn_valid))
		else $error("transaction valid lost");

	// main scenarios reached
	cov_bypass: cover property (@(posedge clk_sys) disable iff (rst)
		txn_valid && !xlate_on && ctrl_reg[CBSC_MTS_BIT]);
	cov_perm: cover property (@(posedge clk_sys) disable iff (rst) out_perm_fault);
	cov_stall: cover property (@(posedge clk_sys) disable iff (rst) fault_stall);
	cov_access: cover property (@(posedge clk_sys) disable iff (rst) out_access_fault);
	cov_reserved: cover property (@(posedge clk_sys) disable iff (rst) attr_reserved);
endmodule : cbsc_top
